/* File: wake_defines.svh */
// Summary of operation
// - In wake detection the transmit data input is ignored and never drives the bus.
// - In wake detection the receive data output stays high until a bus wake-up is recognised.
// - A wake-up is a dominant, recessive, dominant sequence, each symbol lasting at least the filter time.
// - After a valid wake-up the receive data output follows the bus.
// - The whole pattern must arrive within the pattern timeout, else the detector restarts.
// - The operating mode follows the two-flop synchronised enable pin and internal failure events, through a mode register.
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH
// ----------------------------------------
// Timing counts at 20 MHz
// ----------------------------------------
`define WAKE_FILT_CYCLES    32'd20
`define WAKE_TO_CYCLES      32'd4000
`define WAKE_CNT_W          16
`define DOMINANT            1'b0
`endif

/* File: wake_pkg.sv */
package wake_pkg;
   typedef enum logic [2:0] {
      st_idle, st_dom1, st_rec, st_dom2, st_woken
   } wake_state_type;
endpackage : wake_pkg

/* File: symbol_filter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"
module symbol_filter #(
   parameter int unsigned FILT = `WAKE_FILT_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic level_in,
   output logic      level_out
);
   typedef struct packed {
      logic [`WAKE_CNT_W-1:0] cnt;
      logic                   lvl;
   } filt_type;
   filt_type s_r, s_nxt;
   // ----------------------------------------
   // Debounce: level must hold FILT cycles
   // ----------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (level_in == s_r.lvl) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt >= `WAKE_CNT_W'(FILT - 1)) begin
         s_nxt.lvl = level_in;
         s_nxt.cnt = '0;
      end else begin
         s_nxt.cnt = s_r.cnt + `WAKE_CNT_W'(1);
      end
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{cnt: '0, lvl: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign level_out = s_r.lvl;
endmodule : symbol_filter
`default_nettype wire

/* File: can_bus_wakeup_detector.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wake_defines.svh"
module can_bus_wakeup_detector
   import wake_pkg::*;
#(
   parameter int unsigned FILT    = `WAKE_FILT_CYCLES,
   parameter int unsigned TIMEOUT = `WAKE_TO_CYCLES
) (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic can_enable,
   input  wire logic failure_event,
   input  wire logic transmit_data_in,
   input  wire logic bus_rx,
   output logic      bus_tx,
   output logic      receive_data_out,
   output logic      wake_detected
);
   import wake_pkg::*;

   typedef struct packed {
      logic [1:0]             en_s;
      logic [1:0]             bus_s;
      logic [1:0]             txd_s;
      logic                   active;
      wake_state_type         st;
      logic [`WAKE_CNT_W-1:0] to_cnt;
      logic                   tx;
      logic                   rx;
      logic                   woke;
   } state_type;
   state_type s_r, s_nxt;
   logic      bus_f;

   // Pattern under way, so the timeout runs
   function automatic logic in_pattern(input wake_state_type st);
      return st != st_idle && st != st_woken;
   endfunction : in_pattern

   // ----------------------------------------
   // Symbol filter on the synchronised bus
   // ----------------------------------------
   symbol_filter #(.FILT(FILT)) u_filt (
      .clock     (clock),
      .rst_b     (rst_b),
      .level_in  (s_r.bus_s[1]),
      .level_out (bus_f)
   );

   // ----------------------------------------
   // Mode, pattern detector and pin drive
   // ----------------------------------------
   always_comb begin
      s_nxt       = s_r;
      s_nxt.en_s  = {s_r.en_s[0], can_enable};
      s_nxt.bus_s = {s_r.bus_s[0], bus_rx};
      s_nxt.txd_s = {s_r.txd_s[0], transmit_data_in};
      s_nxt.woke  = 1'b0;
      // Failure forces wake detection even with enable high
      s_nxt.active = s_r.en_s[1] && !failure_event;
      if (s_r.active) begin
         s_nxt.st     = st_idle;
         s_nxt.to_cnt = '0;
      end else begin
         if (in_pattern(s_r.st)) begin
            s_nxt.to_cnt = s_r.to_cnt + `WAKE_CNT_W'(1);
         end
         case (s_r.st)
            st_idle: begin
               if (bus_f == `DOMINANT) begin
                  s_nxt.st = st_dom1;
               end
            end
            st_dom1: begin
               if (bus_f != `DOMINANT) begin
                  s_nxt.st = st_rec;
               end
            end
            st_rec: begin
               if (bus_f == `DOMINANT) begin
                  s_nxt.st = st_dom2;
               end
            end
            st_dom2: begin
               if (bus_f != `DOMINANT) begin
                  s_nxt.st   = st_woken;
                  s_nxt.woke = 1'b1;
               end
            end
            st_woken: begin
               s_nxt.st = st_woken;
            end
            default: begin
               s_nxt.st = st_idle;
            end
         endcase
         // Timeout wins over a late completion
         if (in_pattern(s_r.st) && s_r.to_cnt >= `WAKE_CNT_W'(TIMEOUT - 1)) begin
            s_nxt.st     = st_idle;
            s_nxt.to_cnt = '0;
            s_nxt.woke   = 1'b0;
         end
         if (s_nxt.st == st_idle) begin
            s_nxt.to_cnt = '0;
         end
      end
      // Transmitter only from the host while active
      s_nxt.tx = s_r.active ? s_r.txd_s[1] : 1'b1;
      if (s_r.active || s_r.st == st_woken) begin
         s_nxt.rx = s_r.bus_s[1];
      end else begin
         s_nxt.rx = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= '{en_s: 2'h0, bus_s: 2'h3, txd_s: 2'h3, active: 1'b0, st: st_idle,
                  to_cnt: '0, tx: 1'b1, rx: 1'b1, woke: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus_tx           = s_r.tx;
   assign receive_data_out = s_r.rx;
   assign wake_detected    = s_r.woke;
endmodule : can_bus_wakeup_detector
`default_nettype wire

/* File: wake_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module wake_checker #(parameter int unsigned FILT = 3, TIMEOUT = 200) (
   input wire logic clock, rst_b, can_enable, failure_event, transmit_data_in,
   input wire logic bus_rx, bus_tx, receive_data_out, wake_detected
);
   logic [15:0] c1_r, c2_r;
   logic        seen_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Ages of the last two bus falls; no wrap within a run
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         c1_r   <= '0;
         c2_r   <= '0;
         seen_r <= 1'b0;
      end else begin
         c1_r   <= $fell(bus_rx) ? 16'h0 : c1_r + 16'h1;
         c2_r   <= $fell(bus_rx) ? c1_r : c2_r + 16'h1;
         seen_r <= failure_event & (seen_r | wake_detected);
      end
   end
   a_tx_ignored: assert property (failure_event[*3] |-> bus_tx)
      else $error("transmit driven in wake detection");
   a_rx_held: assert property (failure_event[*3] ##0 !seen_r |-> receive_data_out)
      else $error("receive output low before wake");
   a_wake_recess: assert property (wake_detected |-> $past(bus_rx, 1) && $past(bus_rx, FILT))
      else $error("wake without filtered recessive");
   a_rx_follow: assert property (wake_detected ##1 (failure_event && $stable(bus_rx))[*4]
      |-> receive_data_out == bus_rx)
      else $error("receive output not following bus");
   a_wake_in_time: assert property (wake_detected |-> c2_r <= TIMEOUT + FILT + 8)
      else $error("wake after pattern timeout");
   a_active_pass: assert property ((!failure_event && can_enable)[*6] |->
      bus_tx == $past(transmit_data_in, 3) && receive_data_out == $past(bus_rx, 3))
      else $error("active mode not passing data");
   a_wake_single: assert property (wake_detected |=> !wake_detected)
      else $error("wake pulse too long");
   c_wake: cover property (wake_detected);
   c_leave: cover property (failure_event ##1 !failure_event);
   c_rx_low: cover property ($fell(receive_data_out) && failure_event);
endmodule : wake_checker
bind can_bus_wakeup_detector wake_checker #(.FILT(FILT), .TIMEOUT(TIMEOUT)) chk (
   .clock(clock), .rst_b(rst_b), .can_enable(can_enable), .failure_event(failure_event),
   .transmit_data_in(transmit_data_in), .bus_rx(bus_rx), .bus_tx(bus_tx),
   .receive_data_out(receive_data_out), .wake_detected(wake_detected));
`default_nettype wire

/* File: can_bus_node.sv */
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
   input  wire logic bus_tx,
   input  wire logic node_drive,
   output logic      bus_rx
);
   // Wired-AND: any dominant wins, termination pulls recessive
   assign bus_rx = bus_tx & node_drive;
endmodule : can_bus_node
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clock = 0, rst_b = 0, can_enable = 0, failure_event = 1, transmit_data_in = 1;
   logic node_drive = 1, chk_hi = 0, bus_rx, bus_tx, receive_data_out, wake_detected;
   logic [7:0] sid = 0, exp_q[$];
   int n_errors = 0, tests_run = 0, cyc = 0;
   always #25 clock = ~clock;
   can_bus_wakeup_detector #(.FILT(3), .TIMEOUT(200)) dut (.clock(clock), .rst_b(rst_b),
      .can_enable(can_enable), .failure_event(failure_event), .transmit_data_in(transmit_data_in),
      .bus_rx(bus_rx), .bus_tx(bus_tx), .receive_data_out(receive_data_out),
      .wake_detected(wake_detected));
   can_bus_node node (.bus_tx(bus_tx), .node_drive(node_drive), .bus_rx(bus_rx));
   task automatic chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("errors=%0d tests=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task automatic sym(input logic lvl, input int n);
      repeat (n) begin
         @(negedge clock);
         node_drive = lvl;
         transmit_data_in = 1'($urandom);
      end
   endtask : sym
   task automatic pattern(input int d1, r, d2, input bit wake);
      sid++;
      chk_hi = 1;
      if (wake) exp_q.push_back(sid);
      sym(0, d1);
      sym(1, r);
      sym(0, d2);
      chk_hi = 0;
      sym(1, 220);
   endtask : pattern
   // Watcher: pops one note per wake pulse; looks after the edge has settled
   always begin
      @(posedge clock);
      #5;
      if (++cyc > 4000) begin
         n_errors++;
         tally_and_finish();
      end
      if (chk_hi) chk(receive_data_out, 8'h1);
      if (chk_hi) chk(bus_tx, 8'h1);
      if (wake_detected === 1'b1) chk(exp_q.size() ? exp_q.pop_front() : 8'hff, sid);
   end
   initial begin
      void'($urandom(32'h7a29));
      repeat (8) @(negedge clock);
      rst_b = 1;
      pattern(2, 2, 2, 0);
      pattern(100, 150, 20, 0);
      repeat (3) begin
         pattern(4 + $urandom % 40, 4 + $urandom % 40, 4 + $urandom % 40, 1);
         sym(0, 6);
         chk(receive_data_out, 8'h0);
         failure_event = 0;
         can_enable = 1;
         sym(1, 8);
         @(negedge clock);
         transmit_data_in = 0;
         repeat (5) @(negedge clock);
         chk(bus_tx, 8'h0);
         failure_event = 1;
         can_enable = 1'($urandom);
         repeat (3) @(negedge clock);
         chk(receive_data_out, 8'h1);
      end
      chk(8'(exp_q.size()), 8'h0);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
